// ### rtl/dbsc_params.svh
// Constants of the dead-band and shutdown control block: offsets, field positions, reset values.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
`ifndef DBSC_PARAMS_SVH
`define DBSC_PARAMS_SVH

// Register offsets on the plain register port
`define DBSC_OFF_SHUTDOWN_CONTROL 4'h0
`define DBSC_OFF_RISE_COUNT 4'h1
`define DBSC_OFF_FALL_COUNT 4'h2
`define DBSC_OFF_IRQ_STATUS 4'h3
`define DBSC_OFF_IRQ_MASK 4'h4
`define DBSC_OFF_WAVE_CONTROL 4'h5

// Shutdown control fields
`define DBSC_BIT_SHUTDOWN_FLAG 7
`define DBSC_BIT_AUTO_RESTART 6
`define DBSC_BIT_ON_CMP_TWO 3
`define DBSC_BIT_ON_CMP_ONE 2
`define DBSC_BIT_ON_FAULT_PIN 1
`define DBSC_BIT_ON_LOGIC_CELL_TWO 0
`define DBSC_SHUTDOWN_CONTROL_RESET 8'h00

// Dead-band count width and reset fill
`define DBSC_COUNT_WIDTH 6
`define DBSC_COUNT_RESET 6'h00

// Wave control fields
`define DBSC_BIT_ENABLE 0
`define DBSC_BIT_OVR_A 1
`define DBSC_BIT_OVR_B 2

// Interrupt status fields
`define DBSC_IRQ_SHUTDOWN_ENTER 0
`define DBSC_IRQ_SHUTDOWN_LEAVE 1
`define DBSC_IRQ_WIDTH 2

`endif

// ### rtl/dbsc_pkg.sv
// Types shared by the dead-band and shutdown control block.
// Assumes dbsc_params.svh is on the include path.
package dbsc_pkg;
    `include "dbsc_params.svh"

    // Output phase of the waveform path
    typedef enum logic [3:0] {
        DBSC_OVERRIDE = 4'h1,
        DBSC_WAIT_EDGE = 4'h2,
        DBSC_RUN = 4'h4,
        DBSC_IDLE = 4'h8
    } dbsc_phase_t;
endpackage

// ### rtl/dbsc_delay.sv
// Edge delay of one complementary leg: the leg follows its source's rise after a programmed count, its fall at once.
// Assumes a source that is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module dbsc_delay
    import dbsc_pkg::*;
#(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic src,
    input wire logic [W-1:0] count,
    output logic dly
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic out;
    } dbsc_dly_t;

    dbsc_dly_t s_q;
    dbsc_dly_t s_d;

    // Rising edge waits count cycles; a fall passes at once; zero bypasses
    always_comb begin
        s_d = s_q;
        if (!src) begin
            s_d.out = 1'b0;
            s_d.cnt = '0;
        end else if (count == '0) begin
            s_d.out = 1'b1; // [RQ7] [RQ8]
        end else if (!s_q.out) begin
            if (s_q.cnt >= count) begin
                s_d.out = 1'b1; // n counts plus one sampling cycle [RQ7] [RQ8]
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dly = s_q.out;
endmodule // dbsc_delay
`default_nettype wire

// ### rtl/dbsc_ctrl.sv
// Dead-band and auto-shutdown control of a complementary waveform generator.
// Assumes synchronous inputs, one clock, and a plain register port with read data one cycle late.
//
// Function
// RQ1 - Shutdown flag bit 7 is set by a shutdown event and reads one while shut down.
// RQ2 - Auto-restart bit 6 leaves shutdown by itself; otherwise software clears the flag.
// RQ3 - Bit 3 enables shutdown while comparator two output is high.
// RQ4 - Bit 2 enables shutdown while comparator one output is high.
// RQ5 - Bit 1 enables shutdown while the fault pin is low.
// RQ6 - Bit 0 enables shutdown while logic cell two output is high.
// RQ7 - Rising dead band is six-bit n, giving n to n+1 counts, zero none.
// RQ8 - Falling dead band uses its own six-bit count; zero bypasses it.
// RQ9 - Control bits clear on every reset; counts survive non-power resets. The code clears the control bits on rst_n only, not on por_n.
// RQ10 - Shutdown inputs are levels; no exit while an enabled source stays active.
// RQ11 - Auto-restart clears the flag once all enabled sources are inactive.
// RQ12 - Overrides hold after the flag clears until the next input rising edge.
// RQ13 - Software clear of the flag is ignored while a selected source is active.
// RQ14 - Shutdown request is the OR of enabled sources, setting the flag that clock.
`timescale 1ns/1ps
`default_nettype none
module dbsc_ctrl
    import dbsc_pkg::*;
#(
    parameter int COUNT_W = `DBSC_COUNT_WIDTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic wave_input,
    input wire logic cmp_one_output,
    input wire logic cmp_two_output,
    input wire logic logic_cell_two_output,
    input wire logic fault_input_pin_n,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic shutdown_active,
    output logic irq
);
    // Control state in one record; the dead-band counts are kept apart
    typedef struct packed {
        logic shutdown_flag;
        logic auto_restart_enable;
        logic shutdown_on_cmp_two;
        logic shutdown_on_cmp_one;
        logic shutdown_on_fault_pin;
        logic shutdown_on_logic_cell_two;
        logic enable;
        logic ovr_a;
        logic ovr_b;
        logic [`DBSC_IRQ_WIDTH-1:0] irq_status;
        logic [`DBSC_IRQ_WIDTH-1:0] irq_mask;
        logic wave_prev;
        dbsc_phase_t phase;
        logic out_a;
        logic out_b;
        logic [7:0] rdata;
    } dbsc_state_t;

    // Counts kept apart so the power-on reset alone clears them
    typedef struct packed {
        logic [COUNT_W-1:0] rise_delay_count;
        logic [COUNT_W-1:0] fall_delay_count;
    } dbsc_counts_t;

    dbsc_state_t s_q;
    dbsc_state_t s_d;
    dbsc_counts_t c_q;
    dbsc_counts_t c_d;

    logic shutdown_req;
    logic leg_a_src;
    logic leg_b_src;
    logic leg_a_dly;
    logic leg_b_dly;

    // Pads a narrow count into a byte with upper bits zero
    function automatic logic [7:0] dbsc_pad(input logic [COUNT_W-1:0] v);
        logic [7:0] r;
        r = '0;
        r[COUNT_W-1:0] = v;
        return r;
    endfunction

    // Shutdown control register image
    function automatic logic [7:0] dbsc_ctl_image(input dbsc_state_t s);
        logic [7:0] r;
        r = `DBSC_SHUTDOWN_CONTROL_RESET;
        r[`DBSC_BIT_SHUTDOWN_FLAG] = s.shutdown_flag;
        r[`DBSC_BIT_AUTO_RESTART] = s.auto_restart_enable;
        r[`DBSC_BIT_ON_CMP_TWO] = s.shutdown_on_cmp_two;
        r[`DBSC_BIT_ON_CMP_ONE] = s.shutdown_on_cmp_one;
        r[`DBSC_BIT_ON_FAULT_PIN] = s.shutdown_on_fault_pin;
        r[`DBSC_BIT_ON_LOGIC_CELL_TWO] = s.shutdown_on_logic_cell_two;
        return r;
    endfunction

    // Pads an interrupt field into a byte; keeps the read mux free of hand-counted zero fills
    function automatic logic [7:0] dbsc_irq_pad(input logic [`DBSC_IRQ_WIDTH-1:0] v);
        logic [7:0] r;
        r = 8'h00;
        r[`DBSC_IRQ_WIDTH-1:0] = v;
        return r;
    endfunction

    // Wave control register image
    function automatic logic [7:0] dbsc_wave_image(input dbsc_state_t s);
        logic [7:0] r;
        r = 8'h00;
        r[`DBSC_BIT_ENABLE] = s.enable;
        r[`DBSC_BIT_OVR_A] = s.ovr_a;
        r[`DBSC_BIT_OVR_B] = s.ovr_b;
        return r;
    endfunction

    // Low-to-high change between two samples of one level
    function automatic logic dbsc_rose(input logic prev_v, input logic cur_v);
        return cur_v & ~prev_v;
    endfunction

    // Sources are taken as synchronous levels; a raw pin needs a synchroniser upstream
    // OR of every enabled source at its own active level
    assign shutdown_req = (s_q.shutdown_on_cmp_two & cmp_two_output)              // [RQ3] [RQ14]
                        | (s_q.shutdown_on_cmp_one & cmp_one_output)              // [RQ4] [RQ14]
                        | (s_q.shutdown_on_fault_pin & ~fault_input_pin_n)        // [RQ5] [RQ14]
                        | (s_q.shutdown_on_logic_cell_two & logic_cell_two_output); // [RQ6] [RQ14]

    // Complementary legs before dead band: A follows the input, B its inverse
    // Dead band delays rising edges only; falls pass at once, so the legs never overlap
    assign leg_a_src = wave_input;
    assign leg_b_src = ~wave_input;

    // Rising edge of A is delayed by the rise count
    dbsc_delay #(
        .W(COUNT_W)
    ) u_rise (
        .clk(clk),
        .rst_n(rst_n),
        .src(leg_a_src),
        .count(c_q.rise_delay_count),
        .dly(leg_a_dly)
    );

    // Rising edge of B, which is the input falling, is delayed by the fall count
    dbsc_delay #(
        .W(COUNT_W)
    ) u_fall (
        .clk(clk),
        .rst_n(rst_n),
        .src(leg_b_src),
        .count(c_q.fall_delay_count),
        .dly(leg_b_dly)
    );

    // Next-state logic: register port, shutdown flag, phase and outputs
    always_comb begin
        logic wsel;
        logic flag_set;
        logic flag_clr;
        logic [`DBSC_IRQ_WIDTH-1:0] ev;
        wsel = 1'b0;
        flag_set = 1'b0;
        flag_clr = 1'b0;
        ev = '0;
        s_d = s_q;
        c_d = c_q;
        s_d.wave_prev = wave_input;

        // Register writes
        // Status is read-only; a write there or to an unmapped index changes nothing
        if (reg_write) begin
            unique case (reg_addr)
                `DBSC_OFF_SHUTDOWN_CONTROL: begin
                    wsel = 1'b1;
                    s_d.auto_restart_enable = reg_wdata[`DBSC_BIT_AUTO_RESTART];
                    s_d.shutdown_on_cmp_two = reg_wdata[`DBSC_BIT_ON_CMP_TWO];
                    s_d.shutdown_on_cmp_one = reg_wdata[`DBSC_BIT_ON_CMP_ONE];
                    s_d.shutdown_on_fault_pin = reg_wdata[`DBSC_BIT_ON_FAULT_PIN];
                    s_d.shutdown_on_logic_cell_two = reg_wdata[`DBSC_BIT_ON_LOGIC_CELL_TWO];
                end
                `DBSC_OFF_RISE_COUNT: begin
                    c_d.rise_delay_count = reg_wdata[COUNT_W-1:0]; // [RQ7]
                end
                `DBSC_OFF_FALL_COUNT: begin
                    c_d.fall_delay_count = reg_wdata[COUNT_W-1:0]; // [RQ8]
                end
                `DBSC_OFF_IRQ_MASK: begin
                    s_d.irq_mask = reg_wdata[`DBSC_IRQ_WIDTH-1:0];
                end
                `DBSC_OFF_WAVE_CONTROL: begin
                    s_d.enable = reg_wdata[`DBSC_BIT_ENABLE];
                    s_d.ovr_a = reg_wdata[`DBSC_BIT_OVR_A];
                    s_d.ovr_b = reg_wdata[`DBSC_BIT_OVR_B];
                end
                default: begin
                end
            endcase
        end

        // Software may set or clear the flag; a set starts a forced shutdown
        // A forced set lasts one cycle under auto restart, as no source holds it
        if (wsel && reg_wdata[`DBSC_BIT_SHUTDOWN_FLAG]) begin
            flag_set = 1'b1;
        end
        if (wsel && !reg_wdata[`DBSC_BIT_SHUTDOWN_FLAG]) begin
            flag_clr = 1'b1; // [RQ2]
        end

        // Request sets the flag the same clock; it is never cleared while the request stands
        // Level sensitive: the flag cannot drop while any enabled source stays active
        if (shutdown_req) begin
            flag_set = 1'b1; // [RQ1] [RQ14]
            flag_clr = 1'b0; // [RQ10] [RQ13]
        end else if (s_q.auto_restart_enable && s_q.shutdown_flag) begin
            flag_clr = 1'b1; // [RQ2] [RQ11]
        end

        // Set wins over clear
        // A clear in the same cycle as a new request loses, so no shutdown is ever missed
        if (flag_set) begin
            s_d.shutdown_flag = 1'b1; // [RQ1]
        end else if (flag_clr) begin
            s_d.shutdown_flag = 1'b0;
        end

        // Events for the interrupt status, taken from the flag's next value so they line up with it
        ev[`DBSC_IRQ_SHUTDOWN_ENTER] = dbsc_rose(s_q.shutdown_flag, s_d.shutdown_flag);
        ev[`DBSC_IRQ_SHUTDOWN_LEAVE] = dbsc_rose(~s_q.shutdown_flag, ~s_d.shutdown_flag);

        // Read data, registered; a status read clears status but a same-cycle event survives
        s_d.rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                `DBSC_OFF_SHUTDOWN_CONTROL: begin
                    s_d.rdata = dbsc_ctl_image(s_q); // [RQ1]
                end
                `DBSC_OFF_RISE_COUNT: begin
                    s_d.rdata = dbsc_pad(c_q.rise_delay_count); // [RQ7]
                end
                `DBSC_OFF_FALL_COUNT: begin
                    s_d.rdata = dbsc_pad(c_q.fall_delay_count); // [RQ8]
                end
                `DBSC_OFF_IRQ_STATUS: begin
                    s_d.rdata = dbsc_irq_pad(s_q.irq_status);
                    s_d.irq_status = '0;
                end
                `DBSC_OFF_IRQ_MASK: begin
                    s_d.rdata = dbsc_irq_pad(s_q.irq_mask);
                end
                `DBSC_OFF_WAVE_CONTROL: begin
                    s_d.rdata = dbsc_wave_image(s_q);
                end
                default: begin
                    s_d.rdata = 8'h00; // Unmapped indexes read as zero
                end
            endcase
        end
        s_d.irq_status = s_d.irq_status | ev;

        // Output phase: override while flagged, then wait for a rising input edge
        unique case (s_q.phase)
            DBSC_IDLE: begin
                if (s_q.enable) begin
                    s_d.phase = s_q.shutdown_flag ? DBSC_OVERRIDE : DBSC_WAIT_EDGE;
                end
            end
            DBSC_OVERRIDE: begin
                if (!s_q.shutdown_flag) begin
                    s_d.phase = DBSC_WAIT_EDGE; // [RQ12]
                end
            end
            DBSC_WAIT_EDGE: begin
                if (s_q.shutdown_flag) begin
                    s_d.phase = DBSC_OVERRIDE;
                end else if (dbsc_rose(s_q.wave_prev, wave_input)) begin
                    s_d.phase = DBSC_RUN; // [RQ12]
                end
            end
            DBSC_RUN: begin
                if (s_q.shutdown_flag) begin
                    s_d.phase = DBSC_OVERRIDE;
                end
            end
            default: begin
                // An illegal code falls back to idle, where both legs are low
                s_d.phase = DBSC_IDLE;
            end
        endcase
        // A disabled block always rests in idle, whatever the phase was
        if (!s_q.enable) begin
            s_d.phase = DBSC_IDLE;
        end

        // Drive the legs: override levels in shutdown and until the restart edge
        unique case (s_d.phase)
            DBSC_RUN: begin
                s_d.out_a = leg_a_dly;
                s_d.out_b = leg_b_dly;
            end
            DBSC_OVERRIDE, DBSC_WAIT_EDGE: begin
                s_d.out_a = s_q.ovr_a; // [RQ12]
                s_d.out_b = s_q.ovr_b; // [RQ12]
            end
            default: begin
                // Idle drives both legs low
                s_d.out_a = 1'b0;
                s_d.out_b = 1'b0;
            end
        endcase
    end

    // Control state clears on the ordinary reset rst_n only; the power-on reset por_n does not reach it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{phase: DBSC_IDLE, default: '0}; // [RQ9]
        end else begin
            s_q <= s_d;
        end
    end

    // Counts clear only on power-on reset and hold through the ordinary reset
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            c_q <= '0; // [RQ9]
        end else begin
            c_q <= c_d;
        end
    end

    // Every output but irq comes straight from a flip-flop, so no pin glitches on a decode change
    assign reg_rdata = s_q.rdata;
    assign wave_out_a = s_q.out_a;
    assign wave_out_b = s_q.out_b;
    assign shutdown_active = s_q.shutdown_flag; // [RQ1]
    // Level interrupt while any unmasked status bit stands
    assign irq = |(s_q.irq_status & s_q.irq_mask);
endmodule // dbsc_ctrl
`default_nettype wire

// ### sim/dbsc_ctrl_props.sv
// Checker of the control block ports: shutdown request, register port and override levels.
// Assumes a bind to dbsc_ctrl; the control and wave bits are shadowed from register writes.
`timescale 1ns/1ps
`default_nettype none
module dbsc_ctrl_props
    import dbsc_pkg::*;
#(
    parameter int COUNT_W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic cmp_one_output,
    input wire logic cmp_two_output,
    input wire logic logic_cell_two_output,
    input wire logic fault_input_pin_n,
    input wire logic wave_out_a,
    input wire logic wave_out_b,
    input wire logic shutdown_active
);
    logic [7:0] ctl_q;
    logic [2:0] wc_q;
    logic req;
    logic set_wr;
    // Shadow registers, so the request can be rebuilt from the pins alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
            wc_q <= 3'h0;
        end else begin
            if (reg_write && reg_addr == 4'h0) ctl_q <= reg_wdata;
            if (reg_write && reg_addr == 4'h5) wc_q <= reg_wdata[2:0];
        end
    end
    // Fault pin counts when low; the rest when high
    assign req = |(ctl_q[3:0] & {cmp_two_output, cmp_one_output, !fault_input_pin_n, logic_cell_two_output});
    assign set_wr = reg_write && reg_addr == 4'h0 && reg_wdata[7];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_req_sets; req |-> ##[1:2] shutdown_active; endproperty
    a_req_sets: assert property (p_req_sets) else $error("request did not shut down");
    property p_hold; shutdown_active && req |=> shutdown_active; endproperty
    a_hold: assert property (p_hold) else $error("shutdown left while source active");
    property p_auto_clear; (ctl_q[6] && !req && !set_wr) [*3] |-> !shutdown_active; endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("auto restart did not clear");
    property p_override; shutdown_active && $past(shutdown_active) && wc_q[0]
        |-> wave_out_a == wc_q[1] && wave_out_b == wc_q[2]; endproperty
    a_override: assert property (p_override) else $error("outputs not at override levels");
    property p_idle_rdata; !reg_read |=> reg_rdata == 8'h00; endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data not idle");
    property p_unmapped; reg_read && reg_addr > 4'h5 |=> reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_count_top; reg_read && (reg_addr == 4'h1 || reg_addr == 4'h2) |=> reg_rdata[7:6] == 2'b00;
    endproperty
    a_count_top: assert property (p_count_top) else $error("count top bits set");
    property p_ctl_gap; reg_read && reg_addr == 4'h0 |=> reg_rdata[5:4] == 2'b00; endproperty
    a_ctl_gap: assert property (p_ctl_gap) else $error("control unused bits set");
endmodule // dbsc_ctrl_props
`default_nettype wire

// ### sim/dbsc_src_model.sv
// Model of the shutdown sources: two comparators, a logic cell and the fault pin.
// Assumes the bench selects the active sources with a command in control-bit order.
`timescale 1ns/1ps
`default_nettype none
module dbsc_src_model (
    input wire logic [3:0] active,
    output logic cmp_two_output,
    output logic cmp_one_output,
    output logic fault_input_pin_n,
    output logic logic_cell_two_output
);
    // Levels only, held as long as the command says
    assign cmp_two_output = active[3];
    assign cmp_one_output = active[2];
    assign fault_input_pin_n = !active[1];
    assign logic_cell_two_output = active[0];
endmodule // dbsc_src_model
`default_nettype wire

// ### sim/dbsc_ctrl_tb_top.sv
// Testbench of the control block: registers, shutdown sources, restart, overrides, dead band.
// Assumes dbsc_ctrl, dbsc_src_model and dbsc_ctrl_props are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
module dbsc_ctrl_tb_top;
    import dbsc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic wave_input = 1'b0;
    logic [3:0] src = 4'h0;
    logic cmp_one, cmp_two, lc_two, fault_n, wave_out_a, wave_out_b, shutdown_active, irq;
    logic [7:0] rd_v;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    dbsc_src_model u_src (.active(src), .cmp_two_output(cmp_two), .cmp_one_output(cmp_one),
        .fault_input_pin_n(fault_n), .logic_cell_two_output(lc_two));
    dbsc_ctrl dut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .wave_input(wave_input),
        .cmp_one_output(cmp_one), .cmp_two_output(cmp_two), .logic_cell_two_output(lc_two),
        .fault_input_pin_n(fault_n), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
        .shutdown_active(shutdown_active), .irq(irq));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // A hang counts as a mismatch and ends the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // Read data are taken just after the edge that follows the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        rd_v = reg_rdata;
    endtask
    task automatic t_regs();
        rd(4'h0); chk("ctrl_reset", rd_v, 8'h00);
        rd(4'h1); chk("rise_por", rd_v, 8'h00);
        wr(4'h1, 8'hff); wr(4'h2, 8'h41); wr(4'h0, 8'h7f);
        rd(4'h0); chk("ctrl_bits", rd_v, 8'h4f);
        rd(4'h1); chk("rise_bits", rd_v, 8'h3f);
        rd(4'hf); chk("unmapped", rd_v, 8'h00);
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        rd(4'h0); chk("ctrl_rst", rd_v, 8'h00);
        rd(4'h2); chk("fall_kept", rd_v, 8'h01);
    endtask
    // Each source shuts down only when enabled, and auto restart clears it
    task automatic t_src();
        for (int i = 0; i < 4; i++) begin
            wr(4'h0, 8'h40 | (8'h01 << i));
            @(posedge clk) src <= 4'h1 << ((i + 1) % 4);
            step(3); chk("src_off", shutdown_active, 8'h00);
            @(posedge clk) src <= src | (4'h1 << i);
            step(3); chk("src_on", shutdown_active, 8'h01);
            chk("irq_masked", irq, 8'h00);
            rd(4'h0); chk("flag", rd_v, 8'hc0 | (8'h01 << i));
            @(posedge clk) src <= 4'h0;
            step(4); chk("auto_clr", shutdown_active, 8'h00);
        end
    endtask
    task automatic t_soft();
        wr(4'h0, 8'h04);
        @(posedge clk) src <= 4'h4;
        step(3); wr(4'h0, 8'h04);
        step(2); chk("clr_refused", shutdown_active, 8'h01);
        @(posedge clk) src <= 4'h0;
        step(4); chk("sw_hold", shutdown_active, 8'h01);
        wr(4'h0, 8'h04);
        step(3); chk("sw_clr", shutdown_active, 8'h00);
        wr(4'h0, 8'h84);
        step(2); chk("sw_force", shutdown_active, 8'h01);
        wr(4'h0, 8'h04);
        step(2); chk("sw_unforce", shutdown_active, 8'h00);
    endtask
    // Overrides hold past the flag until the input rises; the interrupt follows status and mask
    task automatic t_ovr();
        rd(4'h3); wr(4'h5, 8'h03); wr(4'h4, 8'h01); wr(4'h0, 8'h44);
        @(posedge clk) src <= 4'h4;
        step(3); chk("ovr_a", wave_out_a, 8'h01);
        chk("ovr_b", wave_out_b, 8'h00);
        chk("irq_on", irq, 8'h01);
        @(posedge clk) src <= 4'h0;
        step(5); chk("ovr_hold", wave_out_a, 8'h01);
        rd(4'h3); chk("status", rd_v, 8'h03);
        step(2); chk("irq_off", irq, 8'h00);
        @(posedge clk) wave_input <= 1'b1;
        step(3); chk("run_a", wave_out_a, 8'h00);
        @(posedge clk) wave_input <= 1'b0;
        step(70);
    endtask
    // Each leg rises n+2 edges after the driving edge: one sampling edge, n counts, the output register
    task automatic t_dead();
        int k;
        int n [3] = '{0, 5, 63};
        foreach (n[j]) begin
            wr(4'h1, 8'(n[j])); wr(4'h2, 8'(n[j]));
            step(2);
            @(posedge clk) wave_input <= 1'b1;
            k = 0;
            while (wave_out_a !== 1'b1 && k < 80) begin step(1); k++; end
            chk("rise_dly", 8'(k), 8'(n[j] + 2));
            chk("rise_gap", wave_out_b, 8'h00);
            step(70);
            @(posedge clk) wave_input <= 1'b0;
            k = 0;
            while (wave_out_b !== 1'b1 && k < 80) begin step(1); k++; end
            chk("fall_dly", 8'(k), 8'(n[j] + 2));
            chk("fall_gap", wave_out_a, 8'h00);
            step(70);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        t_regs();
        t_src();
        t_soft();
        t_ovr();
        t_dead();
        stop_test();
    end
endmodule // dbsc_ctrl_tb_top
bind dbsc_ctrl dbsc_ctrl_props #(.COUNT_W(COUNT_W)) u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cmp_one_output(cmp_one_output), .cmp_two_output(cmp_two_output),
    .logic_cell_two_output(logic_cell_two_output), .fault_input_pin_n(fault_input_pin_n),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .shutdown_active(shutdown_active));
`default_nettype wire
